// ### verilog/stage_event_interrupt_logic.v
// Per-step interrupt enables, low limit status and active low interrupt output
//
// Behaviour
// - Completion enable bits 0..11 let that step's finished conversion assert the interrupt.
// - A cleared completion enable keeps that step off the interrupt; enables reset to zero.
// - Completion enable bit 12 lets a level change on the input pin interrupt.
// - Low limit status bits 0..11 report steps whose result passed the low level.
// - Low limit status bits clear on read unless the limit is still exceeded.
// - Separate low interrupt enable register gates low limit events onto the interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "stage_event_irq_map.vh"

module stage_event_interrupt_logic (
	// Clock and reset
	input  wire                      ref_clk,
	input  wire                      sys_rst,
	// Register port
	input  wire [`SEI_ADDR_W-1:0]    regAddr,
	input  wire [`SEI_DATA_W-1:0]    regWrData,
	input  wire                      regWrStrobe,
	input  wire                      regRdStrobe,
	output reg  [`SEI_DATA_W-1:0]    regRdData_q,
	output reg                       regRdValid_q,
	// Converter events
	input  wire [`SEI_STEPS-1:0]     stepDone,
	input  wire [`SEI_STEPS-1:0]     lowLimitExceeded,
	// General purpose input pin
	input  wire                      gpioIn,
	// Interrupt pin
	output reg                       intN_q
);

	// Register storage
	reg  [`SEI_DATA_W-1:0]      lowEnable_q;
	reg  [`SEI_DATA_W-1:0]      lowEnable_d;
	reg  [`SEI_GPIO_EN_BIT:0]   doneEnable_q;
	reg  [`SEI_GPIO_EN_BIT:0]   doneEnable_d;

	// Write strobes
	wire                        wrLowEnable;
	wire                        wrDoneEnable;

	// Pin change detection
	reg                         gpioPrev_q;
	reg                         gpioPrimed_q;
	wire                        gpioChange;

	// Flag banks
	wire [`SEI_STEPS-1:0]       lowFlags;
	wire [`SEI_GPIO_EN_BIT:0]   doneFlags;
	wire [`SEI_STEPS-1:0]       lowClear;
	wire [`SEI_GPIO_EN_BIT:0]   doneClear;
	wire [`SEI_GPIO_EN_BIT:0]   doneSet;

	// Read path
	reg  [`SEI_DATA_W-1:0]      rdData_d;
	wire                        rdLowFlags;
	wire                        rdDoneFlags;

	// Interrupt combine
	wire                        anyPending;
	wire                        lowPending;
	wire                        donePending;
	wire                        gpioPending;

	// Address match against one register offset
	function addrHit;
		input [`SEI_ADDR_W-1:0] addr;
		input [`SEI_ADDR_W-1:0] offset;
		begin
			addrHit = (addr == offset);
		end
	endfunction

	// True when any flag is pending with its enable set
	function anyArmed;
		input [`SEI_STEPS-1:0] flags;
		input [`SEI_STEPS-1:0] enables;
		begin
			anyArmed = |(flags & enables);
		end
	endfunction

	// Writes to status and unmapped offsets fall through unused
	assign wrLowEnable  = regWrStrobe & addrHit(regAddr, `SEI_LOW_EN_OFS);
	assign wrDoneEnable = regWrStrobe & addrHit(regAddr, `SEI_DONE_EN_OFS);

	// Write decode
	always @* begin
		lowEnable_d  = lowEnable_q;
		doneEnable_d = doneEnable_q;
		if (wrLowEnable) begin
			lowEnable_d = regWrData;
		end
		if (wrDoneEnable) begin
			doneEnable_d = regWrData[`SEI_GPIO_EN_BIT:0];
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			lowEnable_q  <= `SEI_LOW_EN_RST;
			doneEnable_q <= `SEI_DONE_EN_RST;
		end else begin
			lowEnable_q  <= lowEnable_d;
			doneEnable_q <= doneEnable_d;
		end
	end

	// Pin sampled as synchronous; first cycle after reset only primes the history
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			gpioPrev_q   <= 1'b0;
			gpioPrimed_q <= 1'b0;
		end else begin
			gpioPrev_q   <= gpioIn;
			gpioPrimed_q <= 1'b1;
		end
	end

	assign gpioChange = gpioPrimed_q & (gpioIn ^ gpioPrev_q);

	assign rdLowFlags  = regRdStrobe & addrHit(regAddr, `SEI_LOW_FLAG_OFS);
	assign rdDoneFlags = regRdStrobe & addrHit(regAddr, `SEI_DONE_FLAG_OFS);

	assign lowClear  = {`SEI_STEPS{rdLowFlags}};
	assign doneClear = {(`SEI_GPIO_EN_BIT + 1){rdDoneFlags}};
	assign doneSet   = {gpioChange, stepDone};

	sticky_event_flags #(
		.WIDTH     (`SEI_STEPS)
	) lowFlagBank (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		// A level still above the limit keeps setting the bit over a read
		.setMask   (lowLimitExceeded),
		.clearMask (lowClear),
		.flags_q   (lowFlags)
	);

	sticky_event_flags #(
		.WIDTH     (`SEI_GPIO_EN_BIT + 1)
	) doneFlagBank (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.setMask   (doneSet),
		.clearMask (doneClear),
		.flags_q   (doneFlags)
	);

	// Read mux; unmapped offsets and unused bits at 0x007, 0x008 and 0x00A read zero; 0x005 returns all 16 bits
	always @* begin
		rdData_d = `SEI_RDATA_RST;
		case (regAddr)
			`SEI_LOW_EN_OFS: begin
				rdData_d = lowEnable_q;
			end
			`SEI_DONE_EN_OFS: begin
				rdData_d[`SEI_GPIO_EN_BIT:0] = doneEnable_q;
			end
			`SEI_LOW_FLAG_OFS: begin
				rdData_d[`SEI_STEP_MSB:`SEI_STEP_LSB] = lowFlags;
			end
			`SEI_DONE_FLAG_OFS: begin
				rdData_d[`SEI_GPIO_EN_BIT:0] = doneFlags;
			end
			default: begin
				rdData_d = `SEI_RDATA_RST;
			end
		endcase
	end

	// Read data is captured before the clear lands, so no event is lost
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			regRdData_q <= `SEI_RDATA_RST;
		end else if (regRdStrobe) begin
			regRdData_q <= rdData_d;
		end
	end

	// Answer strobe trails the request by one fixed cycle
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			regRdValid_q <= 1'b0;
		end else begin
			regRdValid_q <= regRdStrobe;
		end
	end

	assign lowPending  = anyArmed(lowFlags, lowEnable_q[`SEI_STEP_MSB:`SEI_STEP_LSB]);

	assign donePending = anyArmed(doneFlags[`SEI_STEP_MSB:`SEI_STEP_LSB],
		doneEnable_q[`SEI_STEP_MSB:`SEI_STEP_LSB]);

	assign gpioPending = doneFlags[`SEI_GPIO_EN_BIT] & doneEnable_q[`SEI_GPIO_EN_BIT];

	assign anyPending = lowPending | donePending | gpioPending;

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			intN_q <= 1'b1;
		end else begin
			intN_q <= ~anyPending;
		end
	end

endmodule // stage_event_interrupt_logic

`default_nettype wire

// ### common/stage_event_irq_map.vh
// Register map and reset values of the stage event interrupt logic
`ifndef STAGE_EVENT_IRQ_MAP_VH
`define STAGE_EVENT_IRQ_MAP_VH

// Register port geometry
`define SEI_ADDR_W          10
`define SEI_DATA_W          16
`define SEI_STEPS           12

// Register offsets
`define SEI_LOW_EN_OFS      10'h005
`define SEI_DONE_EN_OFS     10'h007
`define SEI_LOW_FLAG_OFS    10'h008
`define SEI_DONE_FLAG_OFS   10'h00A

// Field positions
`define SEI_STEP_LSB        0
`define SEI_STEP_MSB        11
`define SEI_GPIO_EN_BIT     12

// Reset values
`define SEI_LOW_EN_RST      16'h0000
`define SEI_DONE_EN_RST     13'h0000
`define SEI_LOW_FLAG_RST    12'h000
`define SEI_DONE_FLAG_RST   13'h0000
`define SEI_RDATA_RST       16'h0000

`endif

// ### verilog/sticky_event_flags.v
// Sticky event flags, set by hardware and cleared by a register read
`timescale 1ns/1ps
`default_nettype none

module sticky_event_flags #(
	parameter WIDTH = 12
) (
	// Clock and reset
	input  wire             ref_clk,
	input  wire             sys_rst,
	// Events and clear
	input  wire [WIDTH-1:0] setMask,
	input  wire [WIDTH-1:0] clearMask,
	// Flag state
	output reg  [WIDTH-1:0] flags_q
);

	wire [WIDTH-1:0] flags_d;

	// Set wins over a clear arriving in the same cycle
	assign flags_d = (flags_q & ~clearMask) | setMask;

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			flags_q <= {WIDTH{1'b0}};
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule // sticky_event_flags

`default_nettype wire

// ### dv/stage_event_interrupt_logic_sva.sv
// Port assertions for the stage event interrupt logic
`timescale 1ns/1ps
`default_nettype none
module stage_event_interrupt_logic_sva (
	// Clock and register port
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic [9:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        regWrStrobe,
	input wire logic        regRdStrobe,
	input wire logic [15:0] regRdData_q,
	input wire logic        regRdValid_q,
	// Events and interrupt
	input wire logic [11:0] stepDone,
	input wire logic [11:0] lowLimitExceeded,
	input wire logic        gpioIn,
	input wire logic        intN_q
);
	logic [12:0] doneEn_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Mirror of the completion enables at 0x007, so the interrupt checks know what is armed
	always_ff @(posedge ref_clk)
		if (sys_rst) doneEn_q <= 13'h0000;
		else if (regWrStrobe && regAddr == 10'h007) doneEn_q <= regWrData[12:0];
	a_reset_idle: assert property ($fell(sys_rst) |-> intN_q && !regRdValid_q)
		else $error("not idle after reset");
	a_read_answer: assert property (regRdStrobe |=> regRdValid_q)
		else $error("read not answered");
	a_valid_cause: assert property (regRdValid_q |-> $past(regRdStrobe))
		else $error("stray read valid");
	a_unmapped_zero: assert property (
		regRdStrobe && regAddr > 10'h00A |=> regRdData_q == 16'h0000)
		else $error("unmapped read not zero");
	a_enable_top: assert property (
		regRdStrobe && regAddr == 10'h007 |=> regRdData_q[15:13] == 3'h0)
		else $error("unused enable bits set");
	a_low_held: assert property (
		lowLimitExceeded[11] ##1 regRdStrobe && regAddr == 10'h008 |=> regRdData_q[11])
		else $error("low flag lost");
	a_done_irq: assert property (
		|(stepDone & doneEn_q[11:0]) && !regWrStrobe |=> ##1 !intN_q)
		else $error("completion did not interrupt");
	a_pin_irq: assert property (
		gpioIn != $past(gpioIn) && !$past(sys_rst) && doneEn_q[12] && !regWrStrobe |=> ##1 !intN_q)
		else $error("pin change did not interrupt");
endmodule // stage_event_interrupt_logic_sva
bind stage_event_interrupt_logic stage_event_interrupt_logic_sva sva (.*);
`default_nettype wire

// ### dv/host_model.sv
// Host processor model for register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock and read data
	input wire logic         ref_clk,
	input wire logic [15:0]  regRdData_q,
	// Requests
	output logic [9:0]       regAddr = 10'h000,
	output logic [15:0]      regWrData = 16'h0000,
	output logic             regWrStrobe = 1'b0,
	output logic             regRdStrobe = 1'b0
);
	task automatic acc(input logic wr, input logic [9:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= (a == 10'h007) ? (d & 16'h1FFF) : d;
		regWrStrobe <= wr;
		regRdStrobe <= !wr;
		@(posedge ref_clk);
		regWrStrobe <= 1'b0;
		regRdStrobe <= 1'b0;
		// Released address changes, so a stale value cannot pass
		regAddr <= ~a;
		@(negedge ref_clk);
		q = regRdData_q;
	endtask
endmodule // host_model
`default_nettype wire

// ### dv/tb_stage_event_interrupt_logic.sv
// Self-checking bench for the stage event interrupt logic
`timescale 1ns/1ps
`default_nettype none
module tb_stage_event_interrupt_logic;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] stepDone = 12'h000;
	logic [11:0] lowLimitExceeded = 12'h000;
	logic gpioIn = 1'b0;
	logic [15:0] q;
	int failures = 0;
	int num_checks = 0;
	wire logic [9:0] regAddr;
	wire logic [15:0] regWrData, regRdData_q;
	wire logic regWrStrobe, regRdStrobe, regRdValid_q, intN_q;
	always #50 ref_clk = ~ref_clk;
	host_model host (
		.ref_clk     (ref_clk),
		.regRdData_q (regRdData_q),
		.regAddr     (regAddr),
		.regWrData   (regWrData),
		.regWrStrobe (regWrStrobe),
		.regRdStrobe (regRdStrobe)
	);
	stage_event_interrupt_logic dut (
		.ref_clk          (ref_clk),
		.sys_rst          (sys_rst),
		.regAddr          (regAddr),
		.regWrData        (regWrData),
		.regWrStrobe      (regWrStrobe),
		.regRdStrobe      (regRdStrobe),
		.regRdData_q      (regRdData_q),
		.regRdValid_q     (regRdValid_q),
		.stepDone         (stepDone),
		.lowLimitExceeded (lowLimitExceeded),
		.gpioIn           (gpioIn),
		.intN_q           (intN_q)
	);
	task automatic print_verdict;
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [9:0] a, input logic [15:0] e);
		host.acc(1'b0, a, 16'h0000, q);
		chk("regRdData_q", e, q);
	endtask
	// Bounded wait; a miss ends the run
	task automatic irq(input logic v);
		// Look only at falling edges, where the registered output has settled
		@(negedge ref_clk);
		repeat (6) if (intN_q !== v) @(negedge ref_clk);
		chk("intN_q", 16'(v), 16'(intN_q));
		if (intN_q !== v) print_verdict();
	endtask
	task automatic s_reset;
		rd(10'h007, 16'h0000);
		rd(10'h005, 16'h0000);
		rd(10'h008, 16'h0000);
		rd(10'h3FF, 16'h0000);
	endtask
	task automatic s_done;
		host.acc(1'b1, 10'h007, 16'hFFFF, q);
		rd(10'h007, 16'h1FFF);
		host.acc(1'b1, 10'h007, 16'h0008, q);
		@(posedge ref_clk) stepDone <= 12'h010;
		@(posedge ref_clk) stepDone <= 12'h000;
		repeat (3) @(negedge ref_clk);
		irq(1'b1);
		@(posedge ref_clk) stepDone <= 12'h008;
		@(posedge ref_clk) stepDone <= 12'h000;
		irq(1'b0);
		rd(10'h00A, 16'h0018);
		irq(1'b1);
	endtask
	task automatic s_pin;
		// Pin change with its enable still clear must stay silent
		@(posedge ref_clk) gpioIn <= 1'b1;
		repeat (3) @(negedge ref_clk);
		irq(1'b1);
		rd(10'h00A, 16'h1000);
		host.acc(1'b1, 10'h007, 16'h1000, q);
		@(posedge ref_clk) gpioIn <= 1'b0;
		irq(1'b0);
		rd(10'h00A, 16'h1000);
		irq(1'b1);
	endtask
	task automatic s_low;
		@(posedge ref_clk) lowLimitExceeded <= 12'h800;
		rd(10'h008, 16'h0800);
		@(posedge ref_clk) lowLimitExceeded <= 12'h000;
		rd(10'h008, 16'h0800);
		rd(10'h008, 16'h0000);
		host.acc(1'b1, 10'h005, 16'h0800, q);
		rd(10'h005, 16'h0800);
		@(posedge ref_clk) lowLimitExceeded <= 12'h800;
		irq(1'b0);
		@(posedge ref_clk) lowLimitExceeded <= 12'h000;
		rd(10'h008, 16'h0800);
		irq(1'b1);
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		s_reset();
		s_done();
		s_pin();
		s_low();
		print_verdict();
	end
endmodule // tb_stage_event_interrupt_logic
`default_nettype wire
